// file: gri_dev.sv
// device end of the instrument bus port: remote/local, interface messages, framing
//
// Overview of operation
// - in local mode, become remote when the controller requests remote
// - remote lights indicator and blocks panel input except the local-return key
// - settings stay untouched across every remote/local change
// - remote returns local on controller request, or on key unless locked out
// - entering local darkens indicator and re-enables panel input
// - interface clear resets talker and listener and stops transmission
// - remote enable line selects between remote and local control
// - identify, parallel poll, take control and trigger messages are ignored
// - go-to-local while addressed as listener switches to local
// - selected clear drops partial program message and flushes output queue
// - selected clear drops pending completion commands and aborts waits
// - local lockout blocks panel return to local until released
// - universal clear acts exactly like selected clear
// - selected clear needs addressing, universal clear does not
// - serial poll enable puts talker into poll mode
// - serial poll disable restores normal talker operation
// - program message split into semicolon units, kept in received order
// - a message with queries yields exactly one response message
// - message ends on line feed, END with last byte, or line feed with END
// - bus address accepted only in range zero to thirty
// - every response ends with line feed sent with END
// - serial poll answers with the status byte
`timescale 1ns/1ps
`default_nettype none
`include "gri_cfg.svh"

// ----------------------------------------
// receive buffer
// ----------------------------------------
module gri_fifo #(
  parameter int W = 9,
  parameter int D = 8
) (
  // clock and control
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready,
  // fill level
  output logic [$clog2(D+1)-1:0] level
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D+1);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;

  // depth must be a power of two so the pointers wrap on their own
  assign in_ready = (level != CW'(D));
  assign out_valid = (level != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (ce && push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || (ce && flush)) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else if (ce) begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      level <= CW'(level + CW'(push) - CW'(pop));
    end
  end
endmodule // gri_fifo

// ----------------------------------------
// device top
// ----------------------------------------
module gri_dev (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // bus control lines
  input wire logic atn,
  input wire logic ifc,
  input wire logic ren,
  // bus bytes from the controller
  input wire logic bus_valid,
  input wire logic [7:0] bus_data,
  input wire logic bus_end,
  output logic bus_ready,
  // bus bytes to the controller
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_end,
  input wire logic tx_ready,
  // front panel
  input wire logic local_return_key,
  input wire logic [4:0] addr_cfg,
  output logic remote_led,
  output logic panel_enable,
  // program message units to the parser
  output logic unit_valid,
  output gri_pkg::gri_rx_beat_t unit_beat,
  input wire logic unit_ready,
  // responses from the instrument
  input wire logic resp_valid,
  input wire logic [7:0] resp_data,
  input wire logic resp_last,
  output logic resp_ready,
  input wire logic [7:0] status_byte,
  // status to the instrument
  output logic dev_clear,
  output logic [4:0] my_addr,
  output logic listen,
  output logic talk,
  output logic spoll
);
  import gri_pkg::*;

  localparam int CW = $clog2(`GRI_FIFO_DEPTH + 1);
  logic lockout;
  logic cmd_take;
  logic clear_now;
  logic data_push;
  logic fifo_pop;
  logic fifo_valid;
  logic [`GRI_FIFO_WIDTH-1:0] fifo_out;
  logic [CW-1:0] fifo_level;
  logic [CW-1:0] next_level;
  gri_rx_word_t rx_word;
  gri_tx_state_t tx_state;
  logic tx_last;

  function automatic logic is_addr(input logic [7:0] b, input logic [2:0] base,
                                   input logic [4:0] a);
    is_addr = (b[7:5] == base) && (b[4:0] == a);
  endfunction

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  assign cmd_take = ce && atn && bus_valid;
  // universal clear always; selected clear only when addressed to listen
  assign clear_now = cmd_take && ((bus_data == `GRI_CMD_DCL)
                     || (bus_data == `GRI_CMD_SDC && listen));

  always_ff @(posedge clock) begin
    if (rst) begin
      my_addr <= `GRI_ADDR_RST;
    end else if (ce && addr_cfg <= `GRI_ADDR_MAX) begin
      my_addr <= addr_cfg;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || (ce && ifc)) begin
      listen <= 1'b0;
      talk <= 1'b0;
      spoll <= 1'b0;
    end else if (cmd_take) begin
      if (is_addr(bus_data, `GRI_LISTEN_BASE, my_addr)) begin
        listen <= 1'b1;
        talk <= 1'b0;
      end else if (is_addr(bus_data, `GRI_TALK_BASE, my_addr)) begin
        talk <= 1'b1;
        listen <= 1'b0;
      end else if (bus_data == `GRI_UNLISTEN) begin
        listen <= 1'b0;
      end else if (bus_data[7:5] == `GRI_TALK_BASE) begin
        talk <= 1'b0;
      end
      case (bus_data)
        `GRI_CMD_SPE: spoll <= 1'b1;
        `GRI_CMD_SPD: spoll <= 1'b0;
        // identify has no line here; these are taken and dropped
        `GRI_CMD_PPC, `GRI_CMD_GET, `GRI_CMD_TCT, `GRI_CMD_PPU: spoll <= spoll;
        default: spoll <= spoll;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      dev_clear <= 1'b0;
    end else if (ce) begin
      dev_clear <= clear_now;
    end
  end

  // ----------------------------------------
  // remote and local
  // ----------------------------------------
  // mode changes touch only these flags, never the instrument settings
  always_ff @(posedge clock) begin
    if (rst) begin
      remote_led <= 1'b0;
      panel_enable <= 1'b1;
      lockout <= 1'b0;
    end else if (ce) begin
      if (!ren) begin
        remote_led <= 1'b0;
        panel_enable <= 1'b1;
        lockout <= 1'b0;
      end else if (cmd_take && is_addr(bus_data, `GRI_LISTEN_BASE, my_addr)) begin
        remote_led <= 1'b1;
        panel_enable <= 1'b0;
      end else if (cmd_take && bus_data == `GRI_CMD_GTL && listen) begin
        remote_led <= 1'b0;
        panel_enable <= 1'b1;
      end else if (cmd_take && bus_data == `GRI_CMD_LLO) begin
        lockout <= 1'b1;
      end else if (remote_led && local_return_key && !lockout) begin
        remote_led <= 1'b0;
        panel_enable <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // receive path
  // ----------------------------------------
  assign data_push = ce && !atn && bus_valid && listen && bus_ready;
  assign fifo_pop = ce && fifo_valid && (!unit_valid || unit_ready) && !clear_now;
  assign next_level = CW'(fifo_level + CW'(data_push) - CW'(fifo_pop));
  assign rx_word = gri_rx_word_t'(fifo_out);

  gri_fifo #(
    .W(`GRI_FIFO_WIDTH),
    .D(`GRI_FIFO_DEPTH)
  ) gri_fifo_i (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .flush(clear_now || ifc),
    .in_valid(data_push),
    .in_data({bus_end, bus_data}),
    .in_ready(),
    .out_valid(fifo_valid),
    .out_data(fifo_out),
    .out_ready(fifo_pop),
    .level(fifo_level)
  );

  // registered from the next level so the bus sees back-pressure in the cycle the buffer becomes full
  always_ff @(posedge clock) begin
    if (rst) begin
      bus_ready <= 1'b1;
    end else if (ce) begin
      bus_ready <= clear_now || ifc || (next_level < CW'(`GRI_FIFO_DEPTH));
    end
  end

  always_ff @(posedge clock) begin
    if (rst || (ce && (clear_now || ifc))) begin
      unit_valid <= 1'b0;
      unit_beat <= '0;
    end else if (fifo_pop) begin
      unit_valid <= 1'b1;
      if (rx_word.data == `GRI_LINE_FEED) begin
        unit_beat <= '{data: 8'h00, sep: 1'b0, last: 1'b1, empty: 1'b1};
      end else begin
        unit_beat <= '{data: rx_word.data, sep: rx_word.data == `GRI_SEMICOLON,
                       last: rx_word.eom, empty: 1'b0};
      end
    end else if (ce && unit_ready) begin
      unit_valid <= 1'b0;
    end
  end

  // ----------------------------------------
  // talker
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst || (ce && (ifc || clear_now))) begin
      tx_state <= TX_IDLE;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_end <= 1'b0;
      tx_last <= 1'b0;
      resp_ready <= 1'b0;
    end else if (ce) begin
      case (tx_state)
        TX_IDLE: begin
          // a byte already handshaken is taken before poll mode may cut in
          if (resp_valid && resp_ready) begin
            tx_data <= resp_data;
            tx_end <= 1'b0;
            tx_last <= resp_last;
            tx_valid <= 1'b1;
            resp_ready <= 1'b0;
            tx_state <= TX_DATA;
          end else if (talk && !atn && spoll) begin
            tx_data <= status_byte;
            tx_end <= 1'b0;
            tx_valid <= 1'b1;
            resp_ready <= 1'b0;
            tx_state <= TX_POLL;
          end else begin
            resp_ready <= talk && !atn && !spoll;
          end
        end
        TX_DATA: begin
          if (tx_ready) begin
            if (tx_last) begin
              tx_data <= `GRI_LINE_FEED;
              tx_end <= 1'b1;
              tx_state <= TX_TERM;
            end else begin
              tx_valid <= 1'b0;
              tx_state <= TX_IDLE;
            end
          end
        end
        TX_TERM: begin
          if (tx_ready) begin
            tx_valid <= 1'b0;
            tx_end <= 1'b0;
            tx_last <= 1'b0;
            tx_state <= TX_IDLE;
          end
        end
        TX_POLL: begin
          if (tx_ready || !spoll || !talk) begin
            tx_valid <= 1'b0;
            tx_state <= TX_IDLE;
          end
        end
        default: begin
          tx_valid <= 1'b0;
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_remote_on_address;
    cmd_take && ren && !ifc && is_addr(bus_data, `GRI_LISTEN_BASE, my_addr)
      |=> remote_led && !panel_enable;
  endproperty
  a_remote_on_address: assert property (p_remote_on_address)
    else $error("listen address with remote enable did not enter remote");

  property p_lockout_holds;
    ce && ren && remote_led && lockout && !cmd_take |=> remote_led;
  endproperty
  a_lockout_holds: assert property (p_lockout_holds)
    else $error("panel return escaped local lockout");

  property p_key_returns;
    ce && ren && remote_led && !lockout && local_return_key && !cmd_take
      |=> !remote_led ##0 panel_enable;
  endproperty
  a_key_returns: assert property (p_key_returns)
    else $error("local-return key did not restore local mode");

  property p_panel_follows;
    panel_enable == !remote_led;
  endproperty
  a_panel_follows: assert property (p_panel_follows)
    else $error("panel enable disagrees with remote indicator");

  property p_ren_drop;
    ce && !ren |=> !remote_led && !lockout;
  endproperty
  a_ren_drop: assert property (p_ren_drop)
    else $error("remote enable release left remote or lockout");

  property p_dcl_clear;
    cmd_take && bus_data == `GRI_CMD_DCL
      |=> dev_clear ##1 (!dev_clear || $past(clear_now) || !$past(ce));
  endproperty
  a_dcl_clear: assert property (p_dcl_clear)
    else $error("universal clear did not pulse device clear");

  property p_sdc_needs_listen;
    cmd_take && bus_data == `GRI_CMD_SDC && !listen |=> !dev_clear;
  endproperty
  a_sdc_needs_listen: assert property (p_sdc_needs_listen)
    else $error("selected clear acted while not addressed");

  property p_ifc_stops;
    ce && ifc |=> !tx_valid && !talk && !listen && !unit_valid;
  endproperty
  a_ifc_stops: assert property (p_ifc_stops)
    else $error("interface clear left the port active");

  property p_resp_term;
    ce && tx_state == TX_DATA && tx_last && tx_ready && !ifc && !clear_now
      |=> tx_valid && tx_end && tx_data == `GRI_LINE_FEED;
  endproperty
  a_resp_term: assert property (p_resp_term)
    else $error("response not closed by line feed with end");

  property p_addr_range;
    ce && addr_cfg > `GRI_ADDR_MAX |=> $stable(my_addr);
  endproperty
  a_addr_range: assert property (p_addr_range)
    else $error("address outside range was accepted");

  c_remote_to_local: cover property (remote_led ##[1:20] !remote_led);
  c_poll_byte: cover property (tx_state == TX_POLL && tx_ready);
  c_unit_sep: cover property (unit_valid && unit_beat.sep ##[1:20] unit_valid && unit_beat.last);
  c_full_fifo: cover property (!bus_ready && listen);
endmodule // gri_dev
`default_nettype wire

// file: gri_cfg.svh
// constants for the bus remote/local and message framing block
`ifndef GRI_CFG_SVH
`define GRI_CFG_SVH
// ----------------------------------------
// addressing
// ----------------------------------------
`define GRI_ADDR_MAX 5'h1E
`define GRI_ADDR_RST 5'h01
`define GRI_LISTEN_BASE 3'h1
`define GRI_TALK_BASE 3'h2
`define GRI_UNLISTEN 8'h3F
`define GRI_UNTALK 8'h5F
// ----------------------------------------
// interface command codes
// ----------------------------------------
`define GRI_CMD_GTL 8'h01
`define GRI_CMD_SDC 8'h04
`define GRI_CMD_PPC 8'h05
`define GRI_CMD_GET 8'h08
`define GRI_CMD_TCT 8'h09
`define GRI_CMD_LLO 8'h11
`define GRI_CMD_DCL 8'h14
`define GRI_CMD_PPU 8'h15
`define GRI_CMD_SPE 8'h18
`define GRI_CMD_SPD 8'h19
// ----------------------------------------
// message bytes and buffering
// ----------------------------------------
`define GRI_LINE_FEED 8'h0A
`define GRI_SEMICOLON 8'h3B
`define GRI_FIFO_WIDTH 9
`define GRI_FIFO_DEPTH 8
`endif

// file: gri_pkg.sv
// types shared by the bus remote/local and message framing block
`default_nettype none
package gri_pkg;
  // ----------------------------------------
  // receive path
  // ----------------------------------------
  typedef struct packed {
    logic eom;
    logic [7:0] data;
  } gri_rx_word_t;

  typedef struct packed {
    logic [7:0] data;
    logic sep;
    logic last;
    logic empty;
  } gri_rx_beat_t;

  // ----------------------------------------
  // talker states
  // ----------------------------------------
  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_DATA = 4'h2,
    TX_TERM = 4'h4,
    TX_POLL = 4'h8
  } gri_tx_state_t;
endpackage
`default_nettype wire

// file: gri_host_model.sv
// bus controller model that drives the device port from the far side
`timescale 1ns/1ps
`default_nettype none
// ----
// controller model
// ----
module gri_host_model (
  // clock
  input wire logic clock,
  // control lines
  output logic atn,
  output logic ifc,
  output logic ren,
  // bytes to the device
  output logic bus_valid,
  output logic [7:0] bus_data,
  output logic bus_end,
  input wire logic bus_ready,
  // bytes from the device
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_end,
  output logic tx_ready
);
  logic slow = 1'b0;
  logic [8:0] got_q[$];
  initial begin
    {atn, ifc, ren, bus_valid, bus_end, tx_ready} = '0;
    bus_data = 8'h00;
  end
  // slow mode stalls every other cycle, so the talker must hold its byte
  always @(negedge clock) tx_ready <= slow ? ~tx_ready : 1'b1;
  always @(posedge clock) if (tx_valid && tx_ready) got_q.push_back({tx_end, tx_data});
  // single interface only; a command is taken in one cycle
  task automatic cmd(input logic [7:0] b);
    @(negedge clock);
    {atn, bus_valid, bus_data} = {2'b11, b};
    @(negedge clock);
    {atn, bus_valid, bus_data} = {2'b00, ~b};
  endtask
  // ren and ifc are levels owned here; each change lands on a falling edge
  task automatic lines(input logic r, input logic i);
    @(negedge clock);
    {ren, ifc} = {r, i};
  endtask
  // released lines show the inverse so a stale byte never looks like a match
  task automatic dat(input logic [7:0] b, input logic e, output logic ok);
    @(negedge clock);
    {bus_valid, bus_end, bus_data} = {1'b1, e, b};
    ok = 1'b0;
    for (int n = 0; n < 20 && !ok; n++) begin
      @(posedge clock);
      ok = (bus_ready === 1'b1);
    end
    @(negedge clock);
    {bus_valid, bus_end, bus_data} = {2'b00, ~b};
  endtask
endmodule // gri_host_model
`default_nettype wire

// file: gri_dev_tb.sv
// self-checking bench for the device end of the instrument bus port
`timescale 1ns/1ps
`default_nettype none
// ----
// bench top
// ----
module gri_dev_tb;
  import gri_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic local_return_key = 1'b0;
  logic [4:0] addr_cfg = 5'h05;
  logic unit_ready = 1'b0;
  logic resp_valid = 1'b0;
  logic [7:0] resp_data = 8'h00;
  logic resp_last = 1'b0;
  logic [7:0] status_byte = 8'ha5;
  logic atn, ifc, ren, bus_valid, bus_end, bus_ready, tx_valid, tx_end, tx_ready;
  logic [7:0] bus_data, tx_data;
  logic unit_valid, resp_ready, remote_led, panel_enable, dev_clear, listen, talk, spoll;
  logic [4:0] my_addr;
  gri_rx_beat_t unit_beat;
  gri_rx_beat_t beats[$];
  int num_errors = 0;
  int n_compared = 0;
  logic ok;

  always #12.5 clock = ~clock;

  gri_dev gri_dev_i (.clock, .rst, .ce, .atn, .ifc, .ren, .bus_valid, .bus_data, .bus_end,
    .bus_ready, .tx_valid, .tx_data, .tx_end, .tx_ready, .local_return_key, .addr_cfg,
    .remote_led, .panel_enable, .unit_valid, .unit_beat, .unit_ready, .resp_valid,
    .resp_data, .resp_last, .resp_ready, .status_byte, .dev_clear, .my_addr, .listen,
    .talk, .spoll);
  gri_host_model gri_host_model_i (.clock, .atn, .ifc, .ren, .bus_valid, .bus_data,
    .bus_end, .bus_ready, .tx_valid, .tx_data, .tx_end, .tx_ready);

  always @(posedge clock) if (unit_valid && unit_ready) beats.push_back(unit_beat);

  // ----
  // shared tasks
  // ----
  task automatic results;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic cmd(input logic [7:0] b);
    gri_host_model_i.cmd(b);
  endtask
  task automatic send(input logic [7:0] b, input logic e);
    gri_host_model_i.dat(b, e, ok);
    if (!ok) begin
      num_errors++;
      results();
    end
  endtask
  task automatic mode(input logic r);
    chk({remote_led, panel_enable}, {r, ~r});
  endtask
  task automatic press;
    @(negedge clock);
    local_return_key = 1'b1;
    @(negedge clock);
    local_return_key = 1'b0;
  endtask
  task automatic set_ren(input logic v);
    gri_host_model_i.lines(v, 1'b0);
    @(negedge clock);
  endtask
  // bounded wait on the beat queue or on the bytes the controller took
  task automatic wait_n(input int want, input logic on_tx);
    int n;
    int have;
    for (n = 0; n < 60; n++) begin
      have = on_tx ? gri_host_model_i.got_q.size() : beats.size();
      if (have >= want) break;
      @(negedge clock);
    end
    if (n == 60) begin
      num_errors++;
      results();
    end
  endtask
  // request is held until resp_ready is seen high at a rising edge
  task automatic resp(input logic [7:0] b, input logic l);
    @(negedge clock);
    {resp_valid, resp_data, resp_last} = {1'b1, b, l};
    ok = 1'b0;
    for (int n = 0; n < 60 && !ok; n++) begin
      @(posedge clock);
      ok = (resp_ready === 1'b1);
    end
    @(negedge clock);
    resp_valid = 1'b0;
    if (!ok) begin
      num_errors++;
      results();
    end
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_mode;
    set_ren(1'b1);
    cmd(8'h25);
    mode(1'b1);
    press();
    mode(1'b0);
    cmd(8'h25);
    cmd(8'h3f);
    cmd(8'h01);
    mode(1'b1);
    cmd(8'h25);
    cmd(8'h01);
    mode(1'b0);
    cmd(8'h25);
    cmd(8'h11);
    press();
    mode(1'b1);
    set_ren(1'b0);
    mode(1'b0);
    cmd(8'h25);
    mode(1'b0);
    set_ren(1'b1);
    cmd(8'h25);
    press();
    mode(1'b0);
    $display("test mode finished");
  endtask
  task automatic t_ignore;
    logic [7:0] codes[4] = '{8'h05, 8'h08, 8'h09, 8'h15};
    cmd(8'h25);
    foreach (codes[i]) begin
      cmd(codes[i]);
      chk({remote_led, listen, talk, spoll, dev_clear}, 5'h18);
    end
    $display("test ignore finished");
  endtask
  task automatic t_clear;
    beats.delete();
    unit_ready = 1'b0;
    send(8'h41, 1'b0);
    send(8'h42, 1'b0);
    cmd(8'h04);
    chk(dev_clear, 1'b1);
    tick(1);
    chk({dev_clear, unit_valid}, 2'h0);
    cmd(8'h3f);
    cmd(8'h04);
    chk(dev_clear, 1'b0);
    cmd(8'h14);
    chk(dev_clear, 1'b1);
    unit_ready = 1'b1;
    tick(3);
    chk(16'(beats.size()), 16'h0000);
    $display("test clear finished");
  endtask
  task automatic t_frame;
    logic [8:0] msg[7] = '{9'h041, 9'h03b, 9'h042, 9'h10a, 9'h143, 9'h044, 9'h00a};
    logic [10:0] exp[7] = '{11'h208, 11'h1dc, 11'h210, 11'h003, 11'h21a, 11'h220, 11'h003};
    cmd(8'h25);
    beats.delete();
    foreach (msg[i]) send(msg[i][7:0], msg[i][8]);
    wait_n(7, 1'b0);
    foreach (exp[i]) chk(beats[i], exp[i]);
    $display("test frame finished");
  endtask
  // the parser stalls while the port fills, so the buffer must refuse
  task automatic t_fill;
    beats.delete();
    unit_ready = 1'b0;
    // one beat in the output register plus eight in the buffer
    for (int k = 0; k < 9; k++) send(8'h60 + 8'(k), 1'b0);
    tick(1);
    chk(bus_ready, 1'b0);
    unit_ready = 1'b1;
    wait_n(9, 1'b0);
    for (int i = 0; i < 9; i++) chk(beats[i], {8'h60 + 8'(i), 3'h0});
    tick(2);
    chk(unit_valid, 1'b0);
    $display("test fill finished");
  endtask
  task automatic t_resp;
    logic [8:0] exp[3] = '{9'h058, 9'h059, 9'h10a};
    gri_host_model_i.got_q.delete();
    gri_host_model_i.slow = 1'b1;
    cmd(8'h45);
    resp(8'h58, 1'b0);
    resp(8'h59, 1'b1);
    wait_n(3, 1'b1);
    tick(4);
    chk(16'(gri_host_model_i.got_q.size()), 16'h0003);
    foreach (exp[i]) chk(gri_host_model_i.got_q[i], exp[i]);
    gri_host_model_i.slow = 1'b0;
    $display("test resp finished");
  endtask
  task automatic t_poll;
    cmd(8'h18);
    chk(spoll, 1'b1);
    gri_host_model_i.got_q.delete();
    wait_n(1, 1'b1);
    chk(gri_host_model_i.got_q[0], 9'h0a5);
    tick(4);
    chk(resp_ready, 1'b0);
    cmd(8'h19);
    chk(spoll, 1'b0);
    tick(3);
    gri_host_model_i.got_q.delete();
    resp(8'h5a, 1'b1);
    wait_n(2, 1'b1);
    chk(gri_host_model_i.got_q[0], 9'h05a);
    $display("test poll finished");
  endtask
  task automatic t_ifc;
    cmd(8'h18);
    gri_host_model_i.lines(1'b1, 1'b1);
    gri_host_model_i.lines(1'b1, 1'b0);
    chk({listen, talk, spoll, tx_valid, remote_led}, 5'h01);
    $display("test ifc finished");
  endtask
  task automatic t_addr;
    addr_cfg = 5'h1e;
    tick(2);
    chk(my_addr, 5'h1e);
    addr_cfg = 5'h1f;
    tick(2);
    chk(my_addr, 5'h1e);
    cmd(8'h3e);
    chk(listen, 1'b1);
    $display("test addr finished");
  endtask
  // a frozen block must ignore commands and panel keys alike
  task automatic t_freeze;
    ce = 1'b0;
    cmd(8'h3f);
    press();
    chk({remote_led, listen}, 2'h3);
    ce = 1'b1;
    $display("test freeze finished");
  endtask

  // ----
  // main sequence and watchdog
  // ----
  initial begin
    tick(11);
    chk({remote_led, panel_enable, bus_ready, tx_valid, unit_valid, resp_ready, dev_clear,
      listen, talk, spoll, my_addr}, 15'h3001);
    @(negedge clock);
    rst = 1'b0;
    t_mode();
    t_ignore();
    t_clear();
    t_frame();
    t_fill();
    t_resp();
    t_poll();
    t_ifc();
    t_addr();
    t_freeze();
    results();
  end
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    results();
  end
endmodule // gri_dev_tb
`default_nettype wire
